// ---- core/lcmc_pkg.sv ----
`default_nettype none

package lcmc_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_US = 1000;
  // longest time per tick: round down
  localparam int MS_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int POR_SETTLE_US = 100;
  // least time: round up
  localparam int POR_SETTLE_CYCLES =
    (POR_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 11;

  // ----------------------------------------------------------------
  // widths and values after reset
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int LEVEL_W = 8;
  localparam int CODE_W = 4;
  localparam int DUR_W = 14;
  localparam int DRIVE_W = 10;
  localparam int TICK_W = 24;
  localparam logic [7:0] UPDATE_KEY = 8'hc5;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'hff;
  localparam logic [1:0] BAND_RESET = 2'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;

  // output band codes, in quarters of the global maximum
  localparam logic [1:0] BAND_FULL = 2'h0;
  localparam logic [1:0] BAND_3Q = 2'h1;
  localparam logic [1:0] BAND_HALF = 2'h2;
  localparam logic [1:0] BAND_1Q = 2'h3;

  typedef enum logic [6:0] {
    LCMC_PAT_IDLE  = 7'h01,
    LCMC_PAT_START = 7'h02,
    LCMC_PAT_RISE  = 7'h04,
    LCMC_PAT_HOLD  = 7'h08,
    LCMC_PAT_FALL  = 7'h10,
    LCMC_PAT_GAP   = 7'h20,
    LCMC_PAT_OFF   = 7'h40
  } lcmc_pat_state_t;

  typedef enum logic [1:0] {
    LCMC_PUMP_1X  = 2'h1,
    LCMC_PUMP_1P5 = 2'h2
  } lcmc_pump_state_t;

  // phase time in milliseconds for a four-bit code
  function automatic logic [DUR_W-1:0] lcmc_phase_ms(
      input logic [CODE_W-1:0] code);
    case (code)
      4'h0: lcmc_phase_ms = 14'd30;
      4'h1: lcmc_phase_ms = 14'd130;
      4'h2: lcmc_phase_ms = 14'd260;
      4'h3: lcmc_phase_ms = 14'd380;
      4'h4: lcmc_phase_ms = 14'd510;
      4'h5: lcmc_phase_ms = 14'd770;
      4'h6: lcmc_phase_ms = 14'd1040;
      4'h7: lcmc_phase_ms = 14'd1600;
      4'h8: lcmc_phase_ms = 14'd2100;
      4'h9: lcmc_phase_ms = 14'd2600;
      4'ha: lcmc_phase_ms = 14'd3100;
      4'hb: lcmc_phase_ms = 14'd4200;
      4'hc: lcmc_phase_ms = 14'd5200;
      4'hd: lcmc_phase_ms = 14'd6200;
      4'he: lcmc_phase_ms = 14'd7300;
      default: lcmc_phase_ms = 14'd8300;
    endcase
  endfunction : lcmc_phase_ms

endpackage : lcmc_pkg

`default_nettype wire

// ---- core/lcmc_pattern_engine.sv ----
`timescale 1ns/100ps
`default_nettype none

module lcmc_pattern_engine (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire logic enable,
  input wire logic start,
  input wire logic [lcmc_pkg::CODE_W-1:0] start_delay,
  input wire logic [lcmc_pkg::CODE_W-1:0] rise_time,
  input wire logic [lcmc_pkg::CODE_W-1:0] hold_time,
  input wire logic [lcmc_pkg::CODE_W-1:0] fall_time,
  input wire logic [lcmc_pkg::CODE_W-1:0] pulse_gap_time,
  input wire logic [lcmc_pkg::CODE_W-1:0] off_time,
  output logic [lcmc_pkg::LEVEL_W-1:0] level,
  output logic running
);
  import lcmc_pkg::*;

  lcmc_pat_state_t state_q, state_d;
  logic [CODE_W-1:0] ts_q, t1_q, t2_q, t3_q, tp_q, t4_q;
  logic [DUR_W-1:0] elapsed_q, dur;
  logic [LEVEL_W-1:0] level_q, level_d;
  logic [DUR_W+LEVEL_W-1:0] ramp;
  logic phase_done;

  // ----------------------------------------------------------------
  // timing codes, latched only by the update key
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ts_q <= CODE_RESET;
      t1_q <= CODE_RESET;
      t2_q <= CODE_RESET;
      t3_q <= CODE_RESET;
      tp_q <= CODE_RESET;
      t4_q <= CODE_RESET;
    end else if (start) begin
      ts_q <= start_delay;
      t1_q <= rise_time;
      t2_q <= hold_time;
      t3_q <= fall_time;
      tp_q <= pulse_gap_time;
      t4_q <= off_time;
    end
  end

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    case (state_q)
      LCMC_PAT_START: dur = lcmc_phase_ms(ts_q);
      LCMC_PAT_RISE: dur = lcmc_phase_ms(t1_q);
      LCMC_PAT_HOLD: dur = lcmc_phase_ms(t2_q);
      LCMC_PAT_FALL: dur = lcmc_phase_ms(t3_q);
      LCMC_PAT_GAP: dur = lcmc_phase_ms(tp_q);
      default: dur = lcmc_phase_ms(t4_q);
    endcase
  end

  assign phase_done = ms_tick && (elapsed_q + 14'd1 >= dur);

  always_comb begin
    state_d = state_q;
    case (state_q)
      LCMC_PAT_IDLE: state_d = LCMC_PAT_IDLE;
      LCMC_PAT_START: state_d = LCMC_PAT_RISE;
      LCMC_PAT_RISE: state_d = LCMC_PAT_HOLD;
      LCMC_PAT_HOLD: state_d = LCMC_PAT_FALL;
      LCMC_PAT_FALL: state_d = LCMC_PAT_GAP;
      LCMC_PAT_GAP: state_d = LCMC_PAT_OFF;
      // free running: wraps without any host access
      LCMC_PAT_OFF: state_d = LCMC_PAT_RISE;
      default: state_d = LCMC_PAT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !enable) begin
      state_q <= LCMC_PAT_IDLE;
      elapsed_q <= '0;
    end else if (start) begin
      state_q <= LCMC_PAT_START;
      elapsed_q <= '0;
    end else if (phase_done && state_q != LCMC_PAT_IDLE) begin
      state_q <= state_d;
      elapsed_q <= '0;
    end else if (ms_tick && state_q != LCMC_PAT_IDLE) begin
      elapsed_q <= elapsed_q + 14'd1;
    end
  end

  // ----------------------------------------------------------------
  // brightness ramp; a divider, traded for exact linear steps
  // ----------------------------------------------------------------
  always_comb begin
    ramp = (22'(elapsed_q) * 22'(LEVEL_FULL)) / 22'(dur);
    case (state_q)
      LCMC_PAT_RISE: level_d = ramp[LEVEL_W-1:0];
      LCMC_PAT_HOLD: level_d = LEVEL_FULL;
      LCMC_PAT_FALL: level_d = LEVEL_FULL - ramp[LEVEL_W-1:0];
      default: level_d = LEVEL_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_q <= LEVEL_RESET;
    end else begin
      level_q <= level_d;
    end
  end

  assign level = level_q;
  assign running = (state_q != LCMC_PAT_IDLE);

endmodule : lcmc_pattern_engine

`default_nettype wire

// ---- core/lcmc_top.sv ----
// Operation
// - power-up pump mode follows initial select bit
// - stay unity gain until a sink drops out
// - in higher gain, return when headroom suffices
// - hold logic in reset until supply settles
// - shutdown pin rise resets interface, keeps registers
// - register writes accepted while shutdown pin low
// - four global current bands selectable
// - band code scales quarter, half, three-quarter, full
// - select clear gives independent 256-step level mode
// - level N drives N/256 of band current
// - level mode ignores colour; changes only on write
// - select set gives autonomous pattern mode
// - pattern runs delay, rise, hold, fall, gap, off
// - pattern keeps cycling without host access
// - four-bit codes map to sixteen phase times
// - update key loads timing and starts pattern
`timescale 1ns/100ps
`default_nettype none

module lcmc_top #(
  parameter int MS_CYCLES = lcmc_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic supply_good,
  input wire logic shutdown_pin_n,
  input wire logic pump_gain_initial_select,
  input wire logic [lcmc_pkg::NUM_CH-1:0] dropout,
  input wire logic headroom_ok,
  input wire logic [1:0] global_band_select,
  input wire logic [lcmc_pkg::NUM_CH-1:0][1:0] output_band_select,
  input wire logic [lcmc_pkg::NUM_CH-1:0] output_pattern_select,
  input wire logic [lcmc_pkg::NUM_CH-1:0] colour_enable,
  input wire logic [lcmc_pkg::NUM_CH-1:0] level_wr_en,
  input wire logic [lcmc_pkg::LEVEL_W-1:0] level_wr_data,
  input wire logic [lcmc_pkg::NUM_CH-1:0] update_wr_en,
  input wire logic [7:0] update_wr_data,
  input wire logic [lcmc_pkg::NUM_CH-1:0][3:0] start_delay,
  input wire logic [lcmc_pkg::NUM_CH-1:0][3:0] rise_time,
  input wire logic [lcmc_pkg::NUM_CH-1:0][3:0] hold_time,
  input wire logic [lcmc_pkg::NUM_CH-1:0][3:0] fall_time,
  input wire logic [lcmc_pkg::NUM_CH-1:0][3:0] pulse_gap_time,
  input wire logic [lcmc_pkg::NUM_CH-1:0][3:0] off_time,
  output logic [lcmc_pkg::NUM_CH-1:0][lcmc_pkg::DRIVE_W-1:0] out_drive,
  output logic [lcmc_pkg::NUM_CH-1:0] out_on,
  output logic [1:0] global_max_current,
  output logic pump_gain_high,
  output logic por_active,
  output logic i2c_reset,
  output logic [lcmc_pkg::NUM_CH-1:0] pattern_running
);
  import lcmc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic supply_meta_q, supply_sync_q;
  logic sdn_meta_q, sdn_sync_q, sdn_prev_q;
  logic [NUM_CH-1:0] drop_meta_q, drop_sync_q;
  logic head_meta_q, head_sync_q;

  // rst_b only: the shutdown pin must keep being watched during power-up
  // the pin flops start at its idle high level; starting them low would
  // fake a pin rise just after rst_b lifts, while por_q still blocks the interface reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_meta_q <= 1'b0;
      supply_sync_q <= 1'b0;
      sdn_meta_q <= 1'b1;
      sdn_sync_q <= 1'b1;
      drop_meta_q <= '0;
      drop_sync_q <= '0;
      head_meta_q <= 1'b0;
      head_sync_q <= 1'b0;
    end else begin
      supply_meta_q <= supply_good;
      supply_sync_q <= supply_meta_q;
      sdn_meta_q <= shutdown_pin_n;
      sdn_sync_q <= sdn_meta_q;
      drop_meta_q <= dropout;
      drop_sync_q <= drop_meta_q;
      head_meta_q <= headroom_ok;
      head_sync_q <= head_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // power-on hold
  // ----------------------------------------------------------------
  logic [POR_CNT_W-1:0] por_cnt_q;
  logic por_q;
  logic ctl_rst_b;

  // a supply dip restarts the settle wait, so a brown-out is also caught
  always_ff @(posedge clk) begin
    if (!rst_b || !supply_sync_q) begin
      por_cnt_q <= '0;
      por_q <= 1'b1;
    end else if (por_cnt_q == POR_CNT_W'(POR_SETTLE_CYCLES - 1)) begin
      por_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end

  // the synced supply flop joins in directly, so a dip clears the outputs
  // on the same edge that raises por_active, not one clock after it
  assign ctl_rst_b = rst_b && supply_sync_q && !por_q;
  assign por_active = por_q;

  // ----------------------------------------------------------------
  // interface reset on shutdown pin rise
  // ----------------------------------------------------------------
  logic i2c_reset_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sdn_prev_q <= 1'b1;
      i2c_reset_q <= 1'b0;
    end else begin
      sdn_prev_q <= sdn_sync_q;
      // the interface is held anyway while the power-on hold lasts
      i2c_reset_q <= sdn_sync_q && !sdn_prev_q && !por_q;
    end
  end

  assign i2c_reset = i2c_reset_q;

  // writes in the reset cycle belong to a transfer the host should not
  // have made near the pin edge, so they are dropped
  logic wr_ok;
  assign wr_ok = !i2c_reset_q;

  // ----------------------------------------------------------------
  // level registers: written only by the host
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0][LEVEL_W-1:0] level_q;

  // shutdown pin state is not looked at here on purpose
  // a level also survives a spell in pattern mode untouched
  always_ff @(posedge clk) begin
    if (!ctl_rst_b) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (level_wr_en[i] && wr_ok) begin
          level_q[i] <= level_wr_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // global band
  // ----------------------------------------------------------------
  logic [1:0] gband_q;

  always_ff @(posedge clk) begin
    if (!ctl_rst_b) begin
      gband_q <= BAND_RESET;
    end else begin
      gband_q <= global_band_select;
    end
  end

  assign global_max_current = gband_q;

  // ----------------------------------------------------------------
  // pattern engines
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_q;
  logic ms_tick_q;
  logic [NUM_CH-1:0] upd_start;
  logic [NUM_CH-1:0][LEVEL_W-1:0] pat_level;

  // one shared millisecond tick keeps the four patterns in step
  always_ff @(posedge clk) begin
    if (!ctl_rst_b) begin
      tick_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(MS_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      ms_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      ms_tick_q <= 1'b0;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    // any other value written to the update register is ignored
    assign upd_start[g] = update_wr_en[g] && wr_ok &&
                          (update_wr_data == UPDATE_KEY) &&
                          output_pattern_select[g];

    lcmc_pattern_engine lcmc_pattern_engine_i (
      .clk(clk),
      .rst_b(ctl_rst_b),
      .ms_tick(ms_tick_q),
      .enable(output_pattern_select[g]),
      .start(upd_start[g]),
      .start_delay(start_delay[g]),
      .rise_time(rise_time[g]),
      .hold_time(hold_time[g]),
      .fall_time(fall_time[g]),
      .pulse_gap_time(pulse_gap_time[g]),
      .off_time(off_time[g]),
      .level(pat_level[g]),
      .running(pattern_running[g])
    );
  end

  // ----------------------------------------------------------------
  // band scaling and output drive
  // ----------------------------------------------------------------
  function automatic logic [2:0] band_quarters(input logic [1:0] code);
    case (code)
      BAND_1Q: band_quarters = 3'd1;
      BAND_HALF: band_quarters = 3'd2;
      BAND_3Q: band_quarters = 3'd3;
      default: band_quarters = 3'd4;
    endcase
  endfunction : band_quarters

  logic [NUM_CH-1:0][DRIVE_W-1:0] drive_q;
  logic [NUM_CH-1:0] on_q;

  // full scale is 1024: level times quarters, i.e. N/256 of the band
  // the pin is read after its synchroniser, so a shutdown reaches the
  // outputs three clocks late; safer than reading the raw pin
  always_ff @(posedge clk) begin
    if (!ctl_rst_b) begin
      drive_q <= '0;
      on_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!sdn_sync_q) begin
          drive_q[i] <= '0;
          on_q[i] <= 1'b0;
        end else if (output_pattern_select[i]) begin
          // colour enable only matters for patterns
          drive_q[i] <= colour_enable[i] ?
            DRIVE_W'(pat_level[i]) * DRIVE_W'(band_quarters(
              output_band_select[i])) : '0;
          on_q[i] <= colour_enable[i] && (pat_level[i] != LEVEL_RESET);
        end else begin
          drive_q[i] <= DRIVE_W'(level_q[i]) * DRIVE_W'(band_quarters(
            output_band_select[i]));
          on_q[i] <= (level_q[i] != LEVEL_RESET);
        end
      end
    end
  end

  assign out_drive = drive_q;
  assign out_on = on_q;

  // ----------------------------------------------------------------
  // charge pump mode
  // ----------------------------------------------------------------
  lcmc_pump_state_t pump_q, pump_d;
  logic pump_init_q;

  // each mode looks at one input only, so dropout and headroom never
  // fight; a stale headroom reading costs one extra trip at most
  always_comb begin
    pump_d = pump_q;
    case (pump_q)
      LCMC_PUMP_1X: begin
        if (|drop_sync_q) begin
          pump_d = LCMC_PUMP_1P5;
        end
      end
      LCMC_PUMP_1P5: begin
        if (head_sync_q) begin
          pump_d = LCMC_PUMP_1X;
        end
      end
      default: pump_d = LCMC_PUMP_1X;
    endcase
  end

  // the select bit is caught on the first clock after the hold ends
  always_ff @(posedge clk) begin
    if (!ctl_rst_b) begin
      pump_q <= LCMC_PUMP_1X;
      pump_init_q <= 1'b1;
    end else if (pump_init_q) begin
      pump_init_q <= 1'b0;
      pump_q <= pump_gain_initial_select ?
                LCMC_PUMP_1P5 : LCMC_PUMP_1X;
    end else begin
      pump_q <= pump_d;
    end
  end

  assign pump_gain_high = (pump_q == LCMC_PUMP_1P5);

endmodule : lcmc_top

`default_nettype wire

// ---- verification/lcmc_top_props.sv ----
`timescale 1ns/100ps
`default_nettype none

module lcmc_top_props #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic shutdown_pin_n,
  input wire logic pump_gain_initial_select,
  input wire logic [3:0] dropout,
  input wire logic headroom_ok,
  input wire logic [1:0] global_band_select,
  input wire logic [3:0][1:0] output_band_select,
  input wire logic [3:0] output_pattern_select,
  input wire logic [3:0] level_wr_en,
  input wire logic [7:0] level_wr_data,
  input wire logic [3:0] update_wr_en,
  input wire logic [7:0] update_wr_data,
  input wire logic [3:0][9:0] out_drive,
  input wire logic [3:0] out_on,
  input wire logic [1:0] global_max_current,
  input wire logic pump_gain_high,
  input wire logic por_active,
  input wire logic i2c_reset,
  input wire logic [3:0] pattern_running
);
  // cycles since power-on hold ended; the pump start choice is exempt
  logic [3:0] up_q;
  always_ff @(posedge clk) begin
    if (!rst_b || por_active) up_q <= 4'h0;
    else if (up_q != 4'hf) up_q <= up_q + 4'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_por_quiet;
    por_active |-> out_on == 4'h0 && !i2c_reset && !pump_gain_high;
  endproperty
  a_por_quiet: assert property (p_por_quiet)
    else $error("outputs active during power-on hold");
  property p_pump_init;
    $fell(por_active) |-> ##[1:2] pump_gain_high == pump_gain_initial_select;
  endproperty
  a_pump_init: assert property (p_pump_init)
    else $error("pump start mode differs from select");
  property p_pump_up;
    up_q == 4'hf && $rose(pump_gain_high) |->
      $past(|dropout, 2) || $past(|dropout, 3);
  endproperty
  a_pump_up: assert property (p_pump_up)
    else $error("pump gain raised with no dropout");
  property p_pump_down;
    up_q == 4'hf ##0 (headroom_ok && dropout == 4'h0)[*5] |-> !pump_gain_high;
  endproperty
  a_pump_down: assert property (p_pump_down)
    else $error("pump gain kept high with headroom");
  property p_sd_reset;
    $rose(shutdown_pin_n) && !por_active |-> ##[2:4] i2c_reset;
  endproperty
  a_sd_reset: assert property (p_sd_reset)
    else $error("no interface reset after pin rise");
  property p_sd_pulse;
    i2c_reset |=> !i2c_reset;
  endproperty
  a_sd_pulse: assert property (p_sd_pulse)
    else $error("interface reset longer than one cycle");
  property p_level;
    level_wr_en[0] && !i2c_reset && !por_active && !output_pattern_select[0]
      && shutdown_pin_n && $past(shutdown_pin_n, 3) |-> ##2
      out_drive[0] == $past(level_wr_data, 2) * (10'h4 - output_band_select[0]);
  endproperty
  a_level: assert property (p_level)
    else $error("level write gave wrong drive");
  property p_band;
    !por_active && $past(!por_active) |->
      global_max_current == $past(global_band_select);
  endproperty
  a_band: assert property (p_band)
    else $error("global band not taken");
  property p_start;
    update_wr_en[1] && update_wr_data == 8'hc5 && output_pattern_select[1]
      && !i2c_reset && !por_active |=> pattern_running[1];
  endproperty
  a_start: assert property (p_start)
    else $error("update key did not start pattern");
  property p_select_clear;
    !output_pattern_select[1] |=> !pattern_running[1];
  endproperty
  a_select_clear: assert property (p_select_clear)
    else $error("pattern runs in level mode");
endmodule : lcmc_top_props

bind lcmc_top lcmc_top_props #(.MS_CYCLES(MS_CYCLES)) lcmc_top_props_i (
  .clk(clk), .rst_b(rst_b), .shutdown_pin_n(shutdown_pin_n),
  .pump_gain_initial_select(pump_gain_initial_select), .dropout(dropout),
  .headroom_ok(headroom_ok), .global_band_select(global_band_select),
  .output_band_select(output_band_select),
  .output_pattern_select(output_pattern_select), .level_wr_en(level_wr_en),
  .level_wr_data(level_wr_data), .update_wr_en(update_wr_en),
  .update_wr_data(update_wr_data), .out_drive(out_drive), .out_on(out_on),
  .global_max_current(global_max_current), .pump_gain_high(pump_gain_high),
  .por_active(por_active), .i2c_reset(i2c_reset),
  .pattern_running(pattern_running));

`default_nettype wire

// ---- verification/lcmc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module lcmc_host_model (
  input wire logic clk,
  output logic [3:0] level_wr_en,
  output logic [7:0] level_wr_data,
  output logic [3:0] update_wr_en,
  output logic [7:0] update_wr_data,
  output logic shutdown_pin_n
);
  // 10 us of bus silence at 100 ns a cycle
  localparam int QUIET_CYCLES = 100;

  initial begin
    level_wr_en = 4'h0;
    level_wr_data = 8'h00;
    update_wr_en = 4'h0;
    update_wr_data = 8'h00;
    shutdown_pin_n = 1'b1;
  end

  // data is inverted after a write so a stale byte never looks valid
  task automatic write_level(input int ch, input logic [7:0] d);
    @(negedge clk);
    level_wr_en[ch] = 1'b1;
    level_wr_data = d;
    @(negedge clk);
    level_wr_en = 4'h0;
    level_wr_data = ~d;
  endtask : write_level

  task automatic write_update(input int ch, input logic [7:0] d);
    @(negedge clk);
    update_wr_en[ch] = 1'b1;
    update_wr_data = d;
    @(negedge clk);
    update_wr_en = 4'h0;
    update_wr_data = ~d;
  endtask : write_update

  task automatic set_pin(input logic v);
    repeat (QUIET_CYCLES) @(negedge clk);
    shutdown_pin_n = v;
    repeat (QUIET_CYCLES) @(negedge clk);
  endtask : set_pin
endmodule : lcmc_host_model

`default_nettype wire

// ---- verification/lcmc_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module lcmc_bench;
  import lcmc_pkg::*;
  typedef struct packed {
    logic [1:0] band;
    logic [7:0] lvl;
    logic [9:0] exp;
  } lcmc_row_t;
  lcmc_row_t rows [0:4];
  logic clk, rst_b, supply_good, pump_gain_initial_select, headroom_ok;
  logic [3:0] dropout, output_pattern_select, colour_enable;
  logic [1:0] global_band_select;
  logic [3:0][1:0] output_band_select;
  logic [3:0][3:0] start_delay, rise_time, hold_time;
  logic [3:0][3:0] fall_time, pulse_gap_time, off_time;
  wire logic [3:0] level_wr_en, update_wr_en;
  wire logic [7:0] level_wr_data, update_wr_data;
  wire logic shutdown_pin_n;
  logic [3:0][9:0] out_drive;
  logic [3:0] out_on, pattern_running;
  logic [1:0] global_max_current;
  logic pump_gain_high, por_active, i2c_reset;
  int errors = 0, checks_done = 0, cycles = 0, pulses = 0, n;

  lcmc_host_model lcmc_host_model_i (.clk(clk), .level_wr_en(level_wr_en),
    .level_wr_data(level_wr_data), .update_wr_en(update_wr_en),
    .update_wr_data(update_wr_data), .shutdown_pin_n(shutdown_pin_n));

  lcmc_top #(.MS_CYCLES(10)) lcmc_top_i (.clk(clk), .rst_b(rst_b),
    .supply_good(supply_good), .shutdown_pin_n(shutdown_pin_n),
    .pump_gain_initial_select(pump_gain_initial_select), .dropout(dropout),
    .headroom_ok(headroom_ok), .global_band_select(global_band_select),
    .output_band_select(output_band_select),
    .output_pattern_select(output_pattern_select),
    .colour_enable(colour_enable), .level_wr_en(level_wr_en),
    .level_wr_data(level_wr_data), .update_wr_en(update_wr_en),
    .update_wr_data(update_wr_data), .start_delay(start_delay),
    .rise_time(rise_time), .hold_time(hold_time), .fall_time(fall_time),
    .pulse_gap_time(pulse_gap_time), .off_time(off_time),
    .out_drive(out_drive), .out_on(out_on),
    .global_max_current(global_max_current), .pump_gain_high(pump_gain_high),
    .por_active(por_active), .i2c_reset(i2c_reset),
    .pattern_running(pattern_running));

  task automatic check_drive(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t drive %0d expected %0d", $time, got, exp);
    end
  endtask : check_drive

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // bounded wait until the drive of one output equals v
  task automatic wait_drive(input int ch, input logic [9:0] v);
    n = 0;
    while (out_drive[ch] !== v && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_drive

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (i2c_reset === 1'b1) pulses++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    rows[0] = '{2'h1, 8'h04, 10'h00c};
    rows[1] = '{2'h0, 8'h00, 10'h000};
    rows[2] = '{2'h2, 8'h80, 10'h100};
    rows[3] = '{2'h3, 8'h01, 10'h001};
    rows[4] = '{2'h0, 8'hff, 10'h3fc};
    {rst_b, supply_good, headroom_ok, dropout} = 7'h00;
    pump_gain_initial_select = 1'b1;
    global_band_select = 2'h2;
    output_band_select = 8'h00;
    output_pattern_select = 4'h0;
    colour_enable = 4'hf;
    {start_delay, rise_time, fall_time} = 48'h0;
    {pulse_gap_time, off_time} = 32'h0;
    hold_time = 16'h0010;
    repeat (12) @(negedge clk);
    check_bit(por_active, 1'b1);
    check_drive(out_drive[0], 10'h000);
    rst_b = 1'b1;
    supply_good = 1'b1;
    n = 0;
    while (por_active !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check_bit(n >= 1000 && n <= 1008, 1'b1);
    repeat (16) @(negedge clk);
    check_bit(pump_gain_high, 1'b1);
    check_bit(global_max_current == 2'h2, 1'b1);
    headroom_ok = 1'b1;
    repeat (6) @(negedge clk);
    check_bit(pump_gain_high, 1'b0);
    headroom_ok = 1'b0;
    repeat (10) @(negedge clk);
    check_bit(pump_gain_high, 1'b0);
    dropout = 4'h4;
    repeat (6) @(negedge clk);
    check_bit(pump_gain_high, 1'b1);
    dropout = 4'h0;
    foreach (rows[i]) begin
      output_band_select[0] = rows[i].band;
      lcmc_host_model_i.write_level(0, rows[i].lvl);
      repeat (2) @(negedge clk);
      check_drive(out_drive[0], rows[i].exp);
      check_bit(out_on[0], rows[i].exp != 10'h0);
    end
    // level mode must not follow colour bits
    colour_enable = 4'h0;
    repeat (4) @(negedge clk);
    check_drive(out_drive[0], 10'h3fc);
    colour_enable = 4'hf;
    lcmc_host_model_i.set_pin(1'b0);
    lcmc_host_model_i.write_level(0, 8'h10);
    lcmc_host_model_i.set_pin(1'b1);
    check_bit(pulses == 1, 1'b1);
    check_drive(out_drive[0], 10'h040);
    output_pattern_select[1] = 1'b1;
    lcmc_host_model_i.write_update(1, 8'h3a);
    repeat (2) @(negedge clk);
    check_bit(pattern_running[1], 1'b0);
    lcmc_host_model_i.write_update(1, 8'hc5);
    @(negedge clk);
    check_bit(pattern_running[1], 1'b1);
    wait_drive(1, 10'h3fc);
    check_bit(n < 4000, 1'b1);
    n = 0;
    while (out_drive[1] === 10'h3fc && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check_bit(n >= 1295 && n <= 1310, 1'b1);
    wait_drive(1, 10'h000);
    wait_drive(1, 10'h3fc);
    check_bit(n < 4000, 1'b1);
    check_bit(pattern_running[1], 1'b1);
    colour_enable = 4'hd;
    repeat (2) @(negedge clk);
    check_drive(out_drive[1], 10'h000);
    colour_enable = 4'hf;
    repeat (2) @(negedge clk);
    check_drive(out_drive[1], 10'h3fc);
    output_pattern_select[1] = 1'b0;
    repeat (2) @(negedge clk);
    check_bit(pattern_running[1], 1'b0);
    supply_good = 1'b0;
    repeat (4) @(negedge clk);
    check_bit(por_active, 1'b1);
    final_report();
  end
endmodule : lcmc_bench

`default_nettype wire
